// ---- core/dum_sync.sv ----
// two flip-flop synchroniser for the asynchronous modem status pins
`timescale 1ns/1ps
module dum_sync #(
    parameter int         W         = 8,
    parameter logic [W-1:0] IDLE    = '1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    // stage1 is read only by the second stage
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stage1   <= IDLE;
            sync_out <= IDLE;
        end else if (ce) begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : dum_sync

// ---- core/dum_top.sv ----
// modem control and modem status pin logic for both uart channels
`timescale 1ns/1ps

module dum_top (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // control register write and status read strobes from the bus side
    input  wire logic [7:0] mcr_wdata,
    input  wire logic       mcr_wr_a,
    input  wire logic       mcr_wr_b,
    input  wire logic       msr_rd_a,
    input  wire logic       msr_rd_b,
    output logic      [7:0] modem_control_reg_a,
    output logic      [7:0] modem_control_reg_b,
    output logic      [7:0] modem_status_a,
    output logic      [7:0] modem_status_b,
    // interrupt requests from the channel cores
    input  wire logic       irq_req_a,
    input  wire logic       irq_req_b,
    // line side pins
    output logic            term_ready_out_a_n,
    output logic            term_ready_out_b_n,
    output logic            send_request_out_a_n,
    output logic            send_request_out_b_n,
    output logic            aux_out_a_n,
    output logic            aux_out_b_n,
    output logic            irq_out_a,
    output logic            irq_out_a_oe_n,
    output logic            irq_out_b,
    output logic            irq_out_b_oe_n,
    input  wire logic       set_ready_in_a_n,
    input  wire logic       set_ready_in_b_n,
    input  wire logic       carrier_in_a_n,
    input  wire logic       carrier_in_b_n,
    input  wire logic       ring_in_a_n,
    input  wire logic       ring_in_b_n,
    input  wire logic       clear_send_in_a_n,
    input  wire logic       clear_send_in_b_n
);
    localparam int CH  = dum_pkg::CHANNELS;
    localparam int NIN = dum_pkg::PINS_IN;

    logic [dum_pkg::MCR_W-1:0] modem_control_reg      [CH];
    logic [dum_pkg::MSR_W-1:0] msr      [CH];
    logic [NIN-1:0]            pin_sync [CH];
    logic [NIN-1:0]            pin_prev [CH];
    logic [NIN-1:0]            delta    [CH];
    logic [NIN-1:0]            next_delta [CH];
    logic [CH-1:0]             mcr_wr;
    logic [CH-1:0]             msr_rd;
    logic [CH-1:0]             irq_req;
    logic [CH-1:0]             irq_q;
    logic [2*NIN-1:0]          pins_raw;
    logic [2*NIN-1:0]          pins_sync;

    // change events: any edge on cts, set-ready, carrier; ring only
    // when it goes inactive, so a ringing line flags once per burst
    function automatic logic [3:0] dum_events(input logic [3:0] now,
                                              input logic [3:0] was);
        logic [3:0] ev;
        ev = now ^ was;
        ev[dum_pkg::IN_RING] = now[dum_pkg::IN_RING]
                               & ~was[dum_pkg::IN_RING];
        return ev;
    endfunction : dum_events

    assign mcr_wr  = {mcr_wr_b, mcr_wr_a};
    assign msr_rd  = {msr_rd_b, msr_rd_a};
    assign irq_req = {irq_req_b, irq_req_a};

    assign pins_raw = {carrier_in_b_n, ring_in_b_n, set_ready_in_b_n,
                       clear_send_in_b_n,
                       carrier_in_a_n, ring_in_a_n, set_ready_in_a_n,
                       clear_send_in_a_n};

    dum_sync #(
        .W    (2*NIN),
        .IDLE ({dum_pkg::IN_IDLE, dum_pkg::IN_IDLE})
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .async_in (pins_raw),
        .sync_out (pins_sync)
    );

    assign pin_sync[0] = pins_sync[NIN-1:0];
    assign pin_sync[1] = pins_sync[2*NIN-1:NIN];

    // control register per channel, written by the bus side
    always_ff @(posedge sys_clk) begin
        for (int c = 0; c < CH; c++) begin
            if (!rst_n) begin
                modem_control_reg[c] <= dum_pkg::MCR_RESET;
            end else if (ce && mcr_wr[c]) begin
                modem_control_reg[c] <= mcr_wdata;
            end
        end
    end

    // interrupt level is registered so the pin never glitches
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_q <= '0;
        end else if (ce) begin
            irq_q <= irq_req;
        end
    end

    // status inputs only feed the status register, never the datapath
    always_comb begin
        for (int c = 0; c < CH; c++) begin
            next_delta[c] = (msr_rd[c] ? dum_pkg::DELTA_RESET : delta[c])
                            | dum_events(pin_sync[c], pin_prev[c]);
        end
    end

    // a new event in the read cycle survives the clear
    always_ff @(posedge sys_clk) begin
        for (int c = 0; c < CH; c++) begin
            if (!rst_n) begin
                pin_prev[c] <= dum_pkg::IN_IDLE;
                delta[c]    <= dum_pkg::DELTA_RESET;
            end else if (ce) begin
                pin_prev[c] <= pin_sync[c];
                delta[c]    <= next_delta[c];
            end
        end
    end

    always_comb begin
        for (int c = 0; c < CH; c++) begin
            msr[c] = {~pin_sync[c], delta[c]};
        end
    end

    assign modem_status_a      = msr[0];
    assign modem_status_b      = msr[1];
    assign modem_control_reg_a = modem_control_reg[0];
    assign modem_control_reg_b = modem_control_reg[1];

    assign term_ready_out_a_n   = ~modem_control_reg[0][dum_pkg::MCR_TERM_BIT];
    assign term_ready_out_b_n   = ~modem_control_reg[1][dum_pkg::MCR_TERM_BIT];
    assign send_request_out_a_n = ~modem_control_reg[0][dum_pkg::MCR_SEND_BIT];
    assign send_request_out_b_n = ~modem_control_reg[1][dum_pkg::MCR_SEND_BIT];

    // aux pin and interrupt enable share one bit; using the aux pin as
    // a spare output would float or drive the interrupt line with it
    assign aux_out_a_n    = ~modem_control_reg[0][dum_pkg::MCR_AUX_BIT];
    assign aux_out_b_n    = ~modem_control_reg[1][dum_pkg::MCR_AUX_BIT];
    assign irq_out_a_oe_n = ~modem_control_reg[0][dum_pkg::MCR_AUX_BIT];
    assign irq_out_b_oe_n = ~modem_control_reg[1][dum_pkg::MCR_AUX_BIT];
    assign irq_out_a      = irq_q[0];
    assign irq_out_b      = irq_q[1];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_write(int c);
        ce && mcr_wr[c];
    endsequence

    sequence s_ce_run;
        ce [*3];
    endsequence

    logic [CH-1:0] aux_n;
    logic [CH-1:0] oe_n;
    logic [CH-1:0] dtr_n;
    logic [CH-1:0] rts_n;
    assign aux_n = {aux_out_b_n, aux_out_a_n};
    assign oe_n  = {irq_out_b_oe_n, irq_out_a_oe_n};
    assign dtr_n = {term_ready_out_b_n, term_ready_out_a_n};
    assign rts_n = {send_request_out_b_n, send_request_out_a_n};

    for (genvar g = 0; g < CH; g++) begin : g_chk
        a_aux_drive_on: assert property (
            s_write(g) ##0 mcr_wdata[dum_pkg::MCR_AUX_BIT]
            |=> !aux_n[g] && !oe_n[g])
            else $error("aux enable write did not drive interrupt pin");
        a_aux_float_off: assert property (
            s_write(g) ##0 !mcr_wdata[dum_pkg::MCR_AUX_BIT]
            |=> aux_n[g] && oe_n[g])
            else $error("aux disable write did not float interrupt pin");
        a_aux_oe_tied: assert property (
            aux_n[g] == oe_n[g])
            else $error("aux pin and interrupt enable disagree");
        a_reset_aux_high: assert property (
            disable iff (1'b0)
            !rst_n |=> aux_n[g] && oe_n[g] && modem_control_reg[g] == dum_pkg::MCR_RESET)
            else $error("aux pin not high after reset");
        a_dtr_follows: assert property (
            s_write(g) |=> dtr_n[g]
            == !$past(mcr_wdata[dum_pkg::MCR_TERM_BIT]))
            else $error("terminal ready pin does not follow its bit");
        a_rts_follows: assert property (
            s_write(g) |=> rts_n[g]
            == !$past(mcr_wdata[dum_pkg::MCR_SEND_BIT]))
            else $error("request to send pin does not follow its bit");
        a_mcr_hold: assert property (
            !(ce && mcr_wr[g]) |=> $stable(modem_control_reg[g]))
            else $error("control register changed without a write");
        a_delta_sticky: assert property (
            ce && !msr_rd[g] && delta[g] != dum_pkg::DELTA_RESET
            |=> (delta[g] & $past(delta[g])) == $past(delta[g]))
            else $error("status change flag lost before read");
        a_irq_path: assert property (
            ce && modem_control_reg[g][dum_pkg::MCR_AUX_BIT] && irq_req[g]
            |=> irq_q[g])
            else $error("interrupt request not passed to pin");
    end

    a_status_level: assert property (
        s_ce_run ##0 $past(rst_n, 3)
        |-> msr[0][dum_pkg::MSR_W-1:dum_pkg::MSR_LVL_LSB]
            == ~$past(pins_raw[NIN-1:0], 2))
        else $error("status levels do not mirror the pins");
endmodule : dum_top

// ---- inc/dum_pkg.sv ----
// constants shared by the modem pin control block
package dum_pkg;
    localparam int          CHANNELS     = 2;
    localparam int          MCR_W        = 8;
    localparam int          MSR_W        = 8;
    localparam int          PINS_IN      = 4;
    // modem control register field positions
    localparam int          MCR_TERM_BIT = 0;
    localparam int          MCR_SEND_BIT = 1;
    localparam int          MCR_AUX_BIT  = 3;
    localparam logic [7:0]  MCR_RESET    = 8'h00;
    // synchronised status vector order, all active low
    localparam int          IN_CLEAR     = 0;
    localparam int          IN_SET_READY = 1;
    localparam int          IN_RING      = 2;
    localparam int          IN_CARRIER   = 3;
    localparam logic [3:0]  IN_IDLE      = 4'hf;
    // status register: low nibble change flags, high nibble levels
    localparam int          MSR_LVL_LSB  = 4;
    localparam logic [3:0]  DELTA_RESET  = 4'h0;
    localparam int          SYNC_STAGES  = 2;
endpackage : dum_pkg

// ---- verif/dum_modem_model.sv ----
// modem side model driving the active-low status pins of both channels
`timescale 1ns/1ps
module dum_modem_model (
    input  wire logic [3:0] cmd_a,
    input  wire logic [3:0] cmd_b,
    output logic            clear_a_n,
    output logic            set_ready_a_n,
    output logic            ring_a_n,
    output logic            carrier_a_n,
    output logic            clear_b_n,
    output logic            set_ready_b_n,
    output logic            ring_b_n,
    output logic            carrier_b_n
);
    // cmd bit high asserts a line; idle lines sit at the inactive high level
    // serial receive lines are not modelled here; they would idle high
    assign {carrier_a_n, ring_a_n, set_ready_a_n, clear_a_n} = ~cmd_a;
    assign {carrier_b_n, ring_b_n, set_ready_b_n, clear_b_n} = ~cmd_b;
endmodule : dum_modem_model

// ---- verif/dum_top_tb_top.sv ----
// self-checking bench for the modem pin control block
`timescale 1ns/1ps
module dum_top_tb_top;
    logic       sys_clk = 1'b0;
    logic       rst_n   = 1'b0;
    logic       ce      = 1'b1;
    logic [7:0] mcr_wdata = 8'h00;
    logic       mcr_wr_a = 1'b0, mcr_wr_b = 1'b0;
    logic       msr_rd_a = 1'b0, msr_rd_b = 1'b0;
    logic       irq_req_a = 1'b0, irq_req_b = 1'b0;
    logic [3:0] cmd_a = 4'h0, cmd_b = 4'h0;
    logic [7:0] mcr_a, mcr_b, msr_a, msr_b;
    logic       tr_a, tr_b, sr_a, sr_b, ax_a, ax_b;
    logic       io_a, oe_a, io_b, oe_b;
    logic       cs_a, ds_a, ri_a, cd_a, cs_b, ds_b, ri_b, cd_b;
    int         n_mismatch = 0;
    int         num_checks = 0;
    logic [7:0] rows [6] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h0b, 8'hf4};
    logic [7:0] pins [6] = '{8'h0f, 8'h07, 8'h0b, 8'h0c, 8'h00, 8'h0f};
    wire  [7:0] pins_a = {3'h0, io_a, tr_a, sr_a, ax_a, oe_a};
    wire  [7:0] pins_b = {3'h0, io_b, tr_b, sr_b, ax_b, oe_b};

    always #2.5 sys_clk = ~sys_clk;

    dum_modem_model modem (.cmd_a(cmd_a), .cmd_b(cmd_b),
        .clear_a_n(cs_a), .set_ready_a_n(ds_a), .ring_a_n(ri_a),
        .carrier_a_n(cd_a), .clear_b_n(cs_b), .set_ready_b_n(ds_b),
        .ring_b_n(ri_b), .carrier_b_n(cd_b));

    dum_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
        .mcr_wdata(mcr_wdata), .mcr_wr_a(mcr_wr_a), .mcr_wr_b(mcr_wr_b),
        .msr_rd_a(msr_rd_a), .msr_rd_b(msr_rd_b),
        .modem_control_reg_a(mcr_a), .modem_control_reg_b(mcr_b),
        .modem_status_a(msr_a), .modem_status_b(msr_b),
        .irq_req_a(irq_req_a), .irq_req_b(irq_req_b),
        .term_ready_out_a_n(tr_a), .term_ready_out_b_n(tr_b),
        .send_request_out_a_n(sr_a), .send_request_out_b_n(sr_b),
        .aux_out_a_n(ax_a), .aux_out_b_n(ax_b),
        .irq_out_a(io_a), .irq_out_a_oe_n(oe_a),
        .irq_out_b(io_b), .irq_out_b_oe_n(oe_b),
        .set_ready_in_a_n(ds_a), .set_ready_in_b_n(ds_b),
        .carrier_in_a_n(cd_a), .carrier_in_b_n(cd_b),
        .ring_in_a_n(ri_a), .ring_in_b_n(ri_b),
        .clear_send_in_a_n(cs_a), .clear_send_in_b_n(cs_b));

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // software writes only whole control bytes, never toggles aux alone
    task automatic wr(input logic ch, input logic [7:0] d);
        @(posedge sys_clk);
        mcr_wdata <= d;
        mcr_wr_a  <= !ch;
        mcr_wr_b  <= ch;
        tick(1);
        mcr_wr_a  <= 1'b0;
        mcr_wr_b  <= 1'b0;
    endtask : wr

    task automatic rst_check();
        rst_n <= 1'b0;
        tick(3);
        chk("pins_a", 8'h0f, pins_a);
        chk("pins_b", 8'h0f, pins_b);
        chk("mcr_a", 8'h00, mcr_a);
        chk("mcr_b", 8'h00, mcr_b);
        chk("msr_b", 8'h00, msr_b);
        chk("msr_a", 8'h00, msr_a);
        rst_n <= 1'b1;
    endtask : rst_check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    initial begin
        rst_check();
        for (int i = 0; i < 6; i++) begin
            wr(1'b0, rows[i]);
            wr(1'b1, rows[(i + 1) % 6]);
            chk("mcr_a", rows[i], mcr_a);
            chk("mcr_b", rows[(i + 1) % 6], mcr_b);
            chk("pins_a", pins[i], pins_a);
            chk("pins_b", pins[(i + 1) % 6], pins_b);
        end
        rst_check(); // mid-run reset after nonzero control values
        wr(1'b0, 8'h08);
        irq_req_a <= 1'b1;
        irq_req_b <= 1'b1;
        tick(2);
        chk("pins_a", 8'h1c, pins_a);
        chk("pins_b", 8'h1f, pins_b);
        ce <= 1'b0;
        wr(1'b0, 8'h00);
        chk("mcr_a", 8'h08, mcr_a);
        ce <= 1'b1;
        irq_req_a <= 1'b0;
        cmd_a <= 4'hf;
        tick(6);
        chk("msr_a", 8'hfb, msr_a);
        chk("msr_b", 8'h00, msr_b);
        chk("mcr_a", 8'h08, mcr_a);
        msr_rd_a <= 1'b1;
        tick(1);
        msr_rd_a <= 1'b0;
        tick(1);
        chk("msr_a", 8'hf0, msr_a);
        cmd_a <= 4'h0;
        cmd_b <= 4'h5;
        tick(6);
        chk("msr_a", 8'h0f, msr_a);
        chk("msr_b", 8'h51, msr_b);
        complete_run();
    end
endmodule : dum_top_tb_top
